// ==== src/dec_pkg.sv ====
package dec_pkg;

  localparam int NUM_CH = 2;

  // Register offsets
  localparam logic [7:0] OFS_INPUT_STATE = 8'h00;
  localparam logic [7:0] OFS_COUNT_CH1 = 8'h04;
  localparam logic [7:0] OFS_COUNT_CH2 = 8'h06;
  localparam logic [7:0] OFS_FILTER_DELAY = 8'h12;
  localparam logic [7:0] OFS_SETUP_CH1 = 8'h14;
  localparam logic [7:0] OFS_SETUP_CH2 = 8'h16;
  localparam logic [7:0] OFS_EDGE_HOLD = 8'h1A;
  localparam logic [7:0] OFS_HOLD_CLEAR = 8'h1C;

  // Reset values
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] ACK_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Field values
  localparam logic [1:0] MODE_EVENT = 2'h0;
  localparam logic [1:0] MODE_GATE = 2'h1;
  localparam logic [3:0] FREQ_SOFT_FILTER = 4'h1;
  localparam logic [7:0] FILTER_LIMIT = 8'hFA;
  localparam logic [15:0] GATE_MAX = 16'hFFFF;

  // Timing
  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint SAMPLE_US = 64'd200;
  localparam int SAMPLE_CYC = int'((SAMPLE_US * CLK_HZ) / 64'd1_000_000);

  // Gate tick rates in Hz, stepped by a 16-bit fractional accumulator
  localparam int TICK_FRAC_BITS = 16;
  localparam longint TICK_HZ_0 = 64'd48_000_000;
  localparam longint TICK_HZ_1 = 64'd3_000_000;
  localparam longint TICK_HZ_2 = 64'd187_500;
  localparam longint TICK_HZ_3 = 64'd24_000_000;
  localparam longint TICK_HZ_4 = 64'd12_000_000;
  localparam longint TICK_HZ_5 = 64'd6_000_000;
  localparam longint TICK_HZ_6 = 64'd1_500_000;
  localparam longint TICK_HZ_7 = 64'd750_000;
  localparam longint TICK_HZ_8 = 64'd375_000;

  // Counter setup byte
  typedef struct packed {
    logic [1:0] mode;
    logic clr;
    logic rsv;
    logic [3:0] freq;
  } dec_setup_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dec_reg_req_t;

  // Gate measurement states
  typedef enum logic [2:0] {
    GATE_IDLE = 3'b001,
    GATE_WAIT = 3'b010,
    GATE_RUN = 3'b100
  } dec_gate_state_t;

endpackage

// ==== src/dec_input_filter.sv ====
`timescale 1ns/1ps
module dec_input_filter
  import dec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Sampling
  input wire logic sample_en,
  input wire logic din,
  input wire logic [7:0] delay_units,
  // Result
  output logic filt_q
);

  logic [7:0] stable_q;
  logic [7:0] need;
  logic [7:0] limited;

  // Delay is in 100 us units but samples come every 200 us
  always_comb begin
    limited = (delay_units > FILTER_LIMIT) ? FILTER_LIMIT : delay_units;
    need = 8'((9'(limited) + 9'h001) >> 1);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stable_q <= 8'h00;
    end else if (limited == 8'h00 || din == filt_q) begin
      stable_q <= 8'h00;
    end else if (sample_en) begin
      stable_q <= stable_q + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filt_q <= 1'b0;
    end else if (limited == 8'h00) begin
      filt_q <= din; // [RULE21]
    end else if (sample_en && din != filt_q &&
                 stable_q + 8'h01 >= need) begin
      filt_q <= din; // [RULE21]
    end
  end

endmodule

// ==== src/dec_counter_top.sv ====
// Behaviour
// RULE1 - Bits 0,1 show raw input states
// RULE2 - Latch register follows filtered input states
// RULE3 - Plain event mode counts raw rising edges
// RULE4 - Frequency code 1 counts filtered rising edges
// RULE5 - Counters captured at network cycle strobe
// RULE6 - Gate counts ticks while input high
// RULE7 - Gate count saturates at all ones
// RULE8 - Gate result stored at falling edge
// RULE9 - Source keeps gate pause above 100 us
// RULE10 - Only one channel runs gate mode
// RULE11 - Counters are 16 bits, zero after reset
// RULE12 - Bits 0-3 pick gate tick frequency
// RULE13 - Bit 5 rising edge clears counter
// RULE14 - Bits 6-7 select event or gate
// RULE15 - Rising edges latched at 200 us resolution
// RULE16 - Acknowledge dominates over latch set
// RULE17 - Acknowledge bits 0,1 clear latches
// RULE18 - Bus cycle at least 100/150 us
// RULE19 - Update every cycle needs 100/200 us
// RULE20 - Software converts count with tick period
// RULE21 - Filter delay in 100 us units, capped
// RULE22 - Event counter wraps to zero
`timescale 1ns/1ps
module dec_counter_top
  import dec_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Input pins
  input wire logic [NUM_CH-1:0] din_pin,
  // Network cycle capture strobe
  input wire logic cycle_sync,
  // Register access
  input wire dec_reg_req_t reg_req,
  output logic [15:0] reg_rdata_q,
  output logic reg_rvalid_q
);

  localparam int SAMP_W = $clog2(SAMPLE_CYCLES + 1);

  function automatic logic [19:0] tick_step(input logic [3:0] code);
    longint hz;
    case (code)
      4'h0: hz = TICK_HZ_0;
      4'h1: hz = TICK_HZ_1;
      4'h2: hz = TICK_HZ_2;
      4'h3: hz = TICK_HZ_3;
      4'h4: hz = TICK_HZ_4;
      4'h5: hz = TICK_HZ_5;
      4'h6: hz = TICK_HZ_6;
      4'h7: hz = TICK_HZ_7;
      4'h8: hz = TICK_HZ_8;
      default: hz = TICK_HZ_8;
    endcase
    tick_step = 20'((hz << TICK_FRAC_BITS) / CLK_HZ);
  endfunction

  function automatic logic is_setup(input logic [7:0] a, input int ch);
    is_setup = (a == (ch == 0 ? OFS_SETUP_CH1 : OFS_SETUP_CH2));
  endfunction

  // Pin synchronisers
  logic [NUM_CH-1:0] din_m_q;
  logic [NUM_CH-1:0] din_s_q;
  logic [NUM_CH-1:0] din_p_q;
  logic [NUM_CH-1:0] filt;
  logic [NUM_CH-1:0] filt_p_q;
  logic [NUM_CH-1:0] filt_samp_q;

  // Configuration
  logic [7:0] filter_delay_setting_q;
  dec_setup_t setup_q [NUM_CH];
  logic [7:0] ack_q;
  logic [NUM_CH-1:0] tally_clear;

  // Sample tick divider
  logic [SAMP_W-1:0] samp_cnt_q;
  logic samp_en;

  // Counters
  logic [COUNT_W-1:0] count_q [NUM_CH];
  logic [COUNT_W-1:0] cap_q [NUM_CH];
  logic [COUNT_W-1:0] gate_cnt_q [NUM_CH];
  logic [TICK_FRAC_BITS-1:0] frac_q [NUM_CH];
  dec_gate_state_t gate_st_q [NUM_CH];
  logic [NUM_CH-1:0] gate_on;
  logic [NUM_CH-1:0] raw_rise;
  logic [NUM_CH-1:0] raw_fall;
  logic [NUM_CH-1:0] filt_rise;
  logic [NUM_CH-1:0] edge_hold_q;
  logic [19:0] tick_sum [NUM_CH];
  logic [COUNT_W:0] tick_nxt [NUM_CH];
  logic [COUNT_W-1:0] gate_upd [NUM_CH];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      din_m_q <= '0;
      din_s_q <= '0;
      din_p_q <= '0;
    end else begin
      din_m_q <= din_pin;
      din_s_q <= din_m_q;
      din_p_q <= din_s_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      samp_cnt_q <= '0;
    end else if (samp_en) begin
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + SAMP_W'(1);
    end
  end

  assign samp_en = (samp_cnt_q == SAMP_W'(SAMPLE_CYCLES - 1));

  for (genvar g = 0; g < NUM_CH; g++) begin : g_filt
    dec_input_filter u_filt (
      .clock(clock),
      .reset(reset),
      .sample_en(samp_en),
      .din(din_s_q[g]),
      .delay_units(filter_delay_setting_q),
      .filt_q(filt[g])
    );
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filt_p_q <= '0;
    end else begin
      filt_p_q <= filt;
    end
  end

  assign raw_rise = din_s_q & ~din_p_q;
  assign raw_fall = ~din_s_q & din_p_q;
  assign filt_rise = filt & ~filt_p_q;

  // Configuration writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filter_delay_setting_q <= FILTER_RESET;
    end else if (reg_req.wr && reg_req.addr == OFS_FILTER_DELAY) begin
      filter_delay_setting_q <= reg_req.wdata; // [RULE21]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        setup_q[c] <= dec_setup_t'(SETUP_RESET);
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (reg_req.wr && is_setup(reg_req.addr, c)) begin
          setup_q[c] <= dec_setup_t'(reg_req.wdata); // [RULE14]
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tally_clear[c] = reg_req.wr && is_setup(reg_req.addr, c) &&
                       reg_req.wdata[5] && !setup_q[c].clr; // [RULE13]
    end
  end

  // Acknowledge is a level held until software writes it back to 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= ACK_RESET;
    end else if (reg_req.wr && reg_req.addr == OFS_HOLD_CLEAR) begin
      ack_q <= {6'h00, reg_req.wdata[1:0]}; // [RULE17]
    end
  end

  // Second channel is refused gate mode while the first holds it
  always_comb begin
    gate_on[0] = (setup_q[0].mode == MODE_GATE);
    gate_on[1] = (setup_q[1].mode == MODE_GATE) && !gate_on[0]; // [RULE10]
  end

  // Gate measurement sequencing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        gate_st_q[c] <= GATE_IDLE;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        case (gate_st_q[c])
          GATE_IDLE: begin
            if (gate_on[c]) begin
              gate_st_q[c] <= GATE_WAIT;
            end
          end
          GATE_WAIT: begin
            if (!gate_on[c]) begin
              gate_st_q[c] <= GATE_IDLE;
            end else if (raw_rise[c]) begin
              gate_st_q[c] <= GATE_RUN; // [RULE6]
            end
          end
          GATE_RUN: begin
            if (!gate_on[c]) begin
              gate_st_q[c] <= GATE_IDLE;
            end else if (raw_fall[c]) begin
              gate_st_q[c] <= GATE_WAIT; // [RULE8]
            end
          end
          default: gate_st_q[c] <= GATE_IDLE;
        endcase
      end
    end
  end

  // Count including this clock's ticks, so the falling-edge clock is kept
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tick_sum[c] = 20'(frac_q[c]) + tick_step(setup_q[c].freq); // [RULE12]
      tick_nxt[c] = (COUNT_W+1)'(gate_cnt_q[c]) +
                    (COUNT_W+1)'(tick_sum[c][19:16]);
      gate_upd[c] = tick_nxt[c][COUNT_W] ? GATE_MAX[COUNT_W-1:0] :
                    tick_nxt[c][COUNT_W-1:0]; // [RULE7]
    end
  end

  // Tick accumulation; fast rates add several ticks per clock
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        gate_cnt_q[c] <= '0;
        frac_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (gate_st_q[c] != GATE_RUN) begin
          gate_cnt_q[c] <= '0;
          frac_q[c] <= '0;
        end else begin
          frac_q[c] <= tick_sum[c][15:0];
          gate_cnt_q[c] <= gate_upd[c]; // [RULE6]
        end
      end
    end
  end

  // Channel counters
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        count_q[c] <= COUNT_RESET[COUNT_W-1:0]; // [RULE11]
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (tally_clear[c]) begin
          count_q[c] <= '0; // [RULE13]
        end else if (gate_on[c]) begin
          if (gate_st_q[c] == GATE_RUN && raw_fall[c]) begin
            count_q[c] <= gate_upd[c]; // [RULE8]
          end
        end else if (setup_q[c].freq == FREQ_SOFT_FILTER) begin
          if (filt_rise[c]) begin
            count_q[c] <= count_q[c] + COUNT_W'(1); // [RULE4] [RULE22]
          end
        end else if (raw_rise[c]) begin
          count_q[c] <= count_q[c] + COUNT_W'(1); // [RULE3] [RULE22]
        end
      end
    end
  end

  // Snapshot read by the bus for the rest of the cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cap_q[c] <= COUNT_RESET[COUNT_W-1:0];
      end
    end else if (cycle_sync) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cap_q[c] <= count_q[c]; // [RULE5]
      end
    end
  end

  // Edge latch on the filtered input at sample resolution
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filt_samp_q <= '0;
    end else if (samp_en) begin
      filt_samp_q <= filt; // [RULE15]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      edge_hold_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (ack_q[c]) begin
          edge_hold_q[c] <= 1'b0; // [RULE16]
        end else if (samp_en && filt[c] && !filt_samp_q[c]) begin
          edge_hold_q[c] <= 1'b1; // [RULE15] [RULE2]
        end
      end
    end
  end

  // Register reads; write-only and unmapped offsets read zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_req.rd;
      if (reg_req.rd) begin
        case (reg_req.addr)
          OFS_INPUT_STATE: reg_rdata_q <= {14'h0000, din_s_q}; // [RULE1]
          OFS_COUNT_CH1: reg_rdata_q <= 16'(cap_q[0]); // [RULE11]
          OFS_COUNT_CH2: reg_rdata_q <= 16'(cap_q[1]); // [RULE11]
          OFS_EDGE_HOLD: reg_rdata_q <= {14'h0000, edge_hold_q}; // [RULE2]
          default: reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ==== test/dec_counter_props.sv ====
`timescale 1ns/1ps
module dec_counter_props
  import dec_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins and strobe
  input wire logic [NUM_CH-1:0] din_pin,
  input wire logic cycle_sync,
  // Register access
  input wire dec_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [7:0] ack_q;
  logic synced_q;

  // Mirror of the acknowledge byte, since it cannot be read back
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= 8'h00;
    end else if (reg_req.wr && reg_req.addr == OFS_HOLD_CLEAR) begin
      ack_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      synced_q <= 1'b0;
    end else if (cycle_sync) begin
      synced_q <= 1'b1;
    end
  end

  sequence s_rd(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  a_read_answer: assert property (
    reg_req.rd |=> reg_rvalid_q) else $error("read not answered");
  a_no_spurious: assert property (
    !reg_req.rd |=> !reg_rvalid_q) else $error("answer without read");
  a_data_holds: assert property (
    !reg_rvalid_q |-> $stable(reg_rdata_q)) else $error("data moved");
  a_input_state: assert property (
    $stable(din_pin) [*4] ##0 s_rd(OFS_INPUT_STATE)
    |=> reg_rdata_q == {14'h0000, $past(din_pin)})
    else $error("input state wrong");
  a_latch_upper: assert property (
    s_rd(OFS_EDGE_HOLD) |=> reg_rdata_q[15:2] == 14'h0000)
    else $error("latch upper bits set");
  a_wo_zero: assert property (
    s_rd(OFS_SETUP_CH1) or s_rd(OFS_HOLD_CLEAR)
    |=> reg_rdata_q == 16'h0000) else $error("write-only read nonzero");
  a_ack_dominant: assert property (
    ack_q[0] [*4] ##0 s_rd(OFS_EDGE_HOLD) |=> !reg_rdata_q[0])
    else $error("latch set under acknowledge");
  a_count_reset: assert property (
    (!synced_q && !cycle_sync) ##0 s_rd(OFS_COUNT_CH1)
    |=> reg_rdata_q == COUNT_RESET) else $error("count not zero");
endmodule

bind dec_counter_top dec_counter_props #(
  .COUNT_W(COUNT_W),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) dec_counter_props_inst (
  .clock(clock),
  .reset(reset),
  .din_pin(din_pin),
  .cycle_sync(cycle_sync),
  .reg_req(reg_req),
  .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q)
);

// ==== test/dec_cycle_model.sv ====
`timescale 1ns/1ps
module dec_cycle_model #(
  parameter int PERIOD = 2000
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Network cycle strobe
  output logic cycle_sync
);
  int cnt;

  // 200 us cycle: filtering is on, so a faster one would skip updates
  always @(negedge clock or posedge reset) begin
    if (reset) begin
      cnt = 0;
      cycle_sync <= 1'b0;
    end else begin
      cnt = (cnt + 1) % PERIOD;
      cycle_sync <= (cnt == 0);
    end
  end
endmodule

// ==== test/dec_counter_top_test.sv ====
`timescale 1ns/1ps
module dec_counter_top_test
  import dec_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [1:0] din_pin = 2'b00;
  logic cycle_sync;
  dec_reg_req_t reg_req = '0;
  logic [15:0] reg_rdata_q;
  logic reg_rvalid_q;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] rd_v;
  longint exp_g;
  longint hz [9] = '{TICK_HZ_0, TICK_HZ_1, TICK_HZ_2, TICK_HZ_3,
    TICK_HZ_4, TICK_HZ_5, TICK_HZ_6, TICK_HZ_7, TICK_HZ_8};

  dec_counter_top #(.SAMPLE_CYCLES(20)) dec_counter_top_inst (
    .clock(clock),
    .reset(reset),
    .din_pin(din_pin),
    .cycle_sync(cycle_sync),
    .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q)
  );

  dec_cycle_model #(.PERIOD(2000)) dec_cycle_model_inst (
    .clock(clock),
    .reset(reset),
    .cycle_sync(cycle_sync)
  );

  always #50 clock = ~clock;

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      $display("MISMATCH run length expected end seen hang");
      summarize();
    end
  end

  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    reg_req = '0;
  endtask

  // Answer stands one cycle, so it is taken at the next falling edge
  task automatic rd(logic [7:0] a);
    @(negedge clock);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    reg_req = '0;
    check("read valid", 16'h0001, {15'h0000, reg_rvalid_q});
    rd_v = reg_rdata_q;
  endtask

  task automatic rdc(string n, logic [7:0] a, logic [15:0] e);
    rd(a);
    check(n, e, rd_v);
  endtask

  task automatic pulse(logic [1:0] m, int hi, int lo);
    din_pin = din_pin | m;
    repeat (hi) @(negedge clock);
    din_pin = din_pin & ~m;
    repeat (lo) @(negedge clock);
  endtask

  task automatic sync_wait();
    do @(posedge clock); while (cycle_sync !== 1'b1);
  endtask

  initial begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    rdc("count ch1", OFS_COUNT_CH1, COUNT_RESET);
    rdc("count ch2", OFS_COUNT_CH2, COUNT_RESET);
    rdc("setup ch1", OFS_SETUP_CH1, 16'h0000);
    rdc("unmapped", 8'h02, 16'h0000);
    din_pin = 2'b10;
    repeat (4) @(negedge clock);
    rdc("inputs", OFS_INPUT_STATE, 16'h0002);
    din_pin = 2'b01;
    repeat (4) @(negedge clock);
    rdc("inputs", OFS_INPUT_STATE, 16'h0001);
    din_pin = 2'b00;
    wr(OFS_FILTER_DELAY, 8'h04);
    wr(OFS_SETUP_CH2, {MODE_EVENT, 2'b00, FREQ_SOFT_FILTER});
    // Burst shorter than one sample period cannot pass the filter
    repeat (5) pulse(2'b11, 2, 1);
    pulse(2'b11, 200, 200);
    sync_wait();
    // Input checks above left one raw rising edge on each channel
    rdc("raw count", OFS_COUNT_CH1, 16'h0007);
    rdc("filtered count", OFS_COUNT_CH2, 16'h0002);
    pulse(2'b01, 3, 3);
    rdc("held count", OFS_COUNT_CH1, 16'h0007);
    sync_wait();
    rdc("next capture", OFS_COUNT_CH1, 16'h0008);
    rdc("latch", OFS_EDGE_HOLD, 16'h0003);
    wr(OFS_HOLD_CLEAR, 8'h01);
    rdc("latch", OFS_EDGE_HOLD, 16'h0002);
    pulse(2'b01, 200, 200);
    rdc("latch", OFS_EDGE_HOLD, 16'h0002);
    wr(OFS_HOLD_CLEAR, 8'h02);
    rdc("latch", OFS_EDGE_HOLD, 16'h0000);
    wr(OFS_HOLD_CLEAR, 8'h00);
    wr(OFS_SETUP_CH1, 8'h20);
    sync_wait();
    rdc("cleared", OFS_COUNT_CH1, 16'h0000);
    pulse(2'b01, 3, 3);
    wr(OFS_SETUP_CH1, 8'h20);
    sync_wait();
    rdc("not cleared", OFS_COUNT_CH1, 16'h0001);
    // Gate stays on channel one only; channel two remains an event count
    for (int f = 0; f < 9; f++) begin
      wr(OFS_SETUP_CH1, {MODE_GATE, 2'b00, 4'(f)});
      repeat (1000) @(negedge clock);
      pulse(2'b01, 100, 1000);
      sync_wait();
      rd(OFS_COUNT_CH1);
      exp_g = hz[f] * 100 / 10_000_000;
      num_checks++;
      if ($isunknown(rd_v) || rd_v > exp_g + 2 || rd_v + 2 < exp_g) begin
        err_count++;
        $display("MISMATCH gate %0d expected %0d seen %0d", f, exp_g, rd_v);
      end
    end
    wr(OFS_SETUP_CH1, {MODE_GATE, 2'b00, 4'h0});
    pulse(2'b01, 14000, 1000);
    sync_wait();
    rdc("gate overflow", OFS_COUNT_CH1, GATE_MAX);
    summarize();
  end
endmodule
